// *** exposure_trigger_readout_sequencer.sv ***
`timescale 1ns/10ps
module exposure_trigger_readout_sequencer
  import readout_pkg::*;
#(
  parameter int HALF     = HALF_PIX,
  parameter int LINES    = LINE_COUNT_DEF,
  parameter int TAIL_CYC = TAIL_CYC_DEF
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        trigger_in,
  input  wire logic        adc_clk,
  input  wire adc_sample_t adc_data,
  output logic             line_shift,
  output logic             exposure_active_output,
  output logic             frame_active,
  output logic             line_active,
  output logic             pixel_strobe,
  output pixel_pair_t      pixel_pair
);

  localparam int IDX_W = $clog2(HALF);
  localparam logic [IDX_W-1:0] LAST_IDX  = IDX_W'(HALF - 1);
  localparam logic [15:0]      LAST_LINE = 16'(LINES - 1);

  // ==========================================================================
  // Synchronisers
  // ==========================================================================
  logic        trig_s1, trig_s2, trig_s3;
  logic        aclk_s1, aclk_s2, aclk_s3;
  adc_sample_t data_s1, data_s2;
  logic        trig_rise, trig_fall, adc_tick;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      trig_s1 <= 1'b1;
      trig_s2 <= 1'b1;
      trig_s3 <= 1'b1;
    end else begin
      trig_s1 <= trigger_in;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end

  // Data rides two stages like the clock, so it is settled at the tick
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aclk_s1 <= 1'b0;
      aclk_s2 <= 1'b0;
      aclk_s3 <= 1'b0;
      data_s1 <= '0;
      data_s2 <= '0;
    end else begin
      aclk_s1 <= adc_clk;
      aclk_s2 <= aclk_s1;
      aclk_s3 <= aclk_s2;
      data_s1 <= adc_data;
      data_s2 <= data_s1;
    end
  end

  assign trig_rise = trig_s2 & ~trig_s3;
  assign trig_fall = ~trig_s2 & trig_s3;
  assign adc_tick  = aclk_s2 & ~aclk_s3;

  // ==========================================================================
  // Register file
  // ==========================================================================
  logic [31:0] ctrl, expo_time, timer2, frame_count, rd_mux;
  expo_mode_t  mode;
  logic        run, bus_wr;
  expo_state_t xstate;
  read_state_t rstate;

  function automatic logic [31:0] merge_be(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge_be

  assign mode   = expo_mode_t'(ctrl[CTRL_MODE_LSB +: 2]);
  assign run    = ctrl[CTRL_RUN_BIT];
  assign bus_wr = avs_write & ~avs_waitrequest;

  // mode and exposure set by command
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl      <= CTRL_RST;
      expo_time <= EXPOSURE_RST;
      timer2    <= TIMER2_RST;
    end else if (bus_wr) begin
      case (avs_address)
        ADDR_CTRL: begin
          ctrl <= merge_be(ctrl, avs_writedata, avs_byteenable) & 32'h0000_0007;
        end
        ADDR_EXPOSURE: begin
          expo_time <= merge_be(expo_time, avs_writedata, avs_byteenable);
        end
        ADDR_TIMER2: begin
          timer2 <= merge_be(timer2, avs_writedata, avs_byteenable);
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      ADDR_CTRL:     rd_mux = ctrl;
      ADDR_EXPOSURE: rd_mux = expo_time;
      ADDR_TIMER2:   rd_mux = timer2;
      ADDR_STATUS: begin
        rd_mux[ST_EXPO_BIT]            = exposure_active_output;
        rd_mux[ST_FRAME_BIT]           = frame_active;
        rd_mux[ST_LINE_BIT]            = line_active;
        rd_mux[ST_XSTATE_LSB +: 4]     = xstate;
        rd_mux[ST_RSTATE_LSB +: 4]     = rstate;
      end
      ADDR_FRAMES:   rd_mux = frame_count;
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // One wait cycle, then a single cycle with waitrequest low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      if (!avs_waitrequest) begin
        avs_waitrequest <= 1'b1;
      end else if (avs_read | avs_write) begin
        avs_waitrequest <= 1'b0;
      end
      if (avs_waitrequest && avs_read) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // ==========================================================================
  // Exposure sequencer
  // ==========================================================================
  logic [31:0] cnt;
  logic        busy_start;
  expo_mode_t  cur_mode;
  logic        frame_go;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      xstate                 <= X_IDLE;
      cnt                    <= 32'h0000_0000;
      busy_start             <= 1'b0;
      cur_mode               <= MODE_LEVEL;
      frame_go               <= 1'b0;
      exposure_active_output <= 1'b0;
    end else begin
      frame_go <= 1'b0;
      case (xstate)
        X_IDLE: begin
          if (run) begin
            case (mode)
              MODE_LEVEL: begin
                if (trig_fall) begin
                  cur_mode   <= MODE_LEVEL;
                  busy_start <= frame_active;
                  cnt        <= frame_active ? 32'(JITTER_MAX_CYC - 1)
                                             : 32'(IDLE_DLY_CYC - 1);
                  xstate     <= X_DELAY;
                end
              end
              MODE_PROG: begin
                if (trig_rise) begin
                  cur_mode               <= MODE_PROG;
                  cnt                    <= expo_time;
                  xstate                 <= X_EXPOSE;
                  exposure_active_output <= 1'b1;
                end
              end
              MODE_FREE: begin
                if (adc_tick) begin
                  if (cnt == 32'h0000_0000) begin
                    cur_mode               <= MODE_FREE;
                    cnt                    <= expo_time;
                    xstate                 <= X_EXPOSE;
                    exposure_active_output <= 1'b1;
                  end else begin
                    cnt <= cnt - 32'h0000_0001;
                  end
                end
              end
              default: ;
            endcase
          end
        end
        X_DELAY: begin
          // start when the count runs out, or as soon as the frame goes idle after a busy start
          if (cnt == 32'h0000_0000 || (busy_start && !frame_active)) begin
            xstate                 <= X_EXPOSE;
            exposure_active_output <= 1'b1;
          end else begin
            cnt <= cnt - 32'h0000_0001;
          end
        end
        X_EXPOSE: begin
          if (cur_mode == MODE_LEVEL) begin
            // tail after rise gives low time plus tail after an idle start; after a busy start, low time less its delay, plus tail
            if (trig_rise) begin
              cnt    <= busy_start ? 32'(TAIL_CYC - 1)
                                   : 32'(TAIL_CYC + IDLE_DLY_CYC - 1);
              xstate <= X_TAIL;
            end
          end else if (adc_tick) begin
            if (cnt == 32'h0000_0000) begin
              cnt    <= 32'(TAIL_CYC - 1);
              xstate <= X_TAIL;
            end else begin
              cnt <= cnt - 32'h0000_0001;
            end
          end
        end
        X_TAIL: begin
          if (cnt == 32'h0000_0000) begin
            exposure_active_output <= 1'b0;
            frame_go               <= 1'b1;
            xstate                 <= X_IDLE;
            cnt                    <= timer2;
          end else begin
            cnt <= cnt - 32'h0000_0001;
          end
        end
        default: xstate <= X_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Readout and video
  // ==========================================================================
  logic [IDX_W-1:0] idx;
  logic [15:0]      line_no;
  logic             mem_wr;
  logic             go_pend;
  pixel_pair_t      rd_pair;

  assign mem_wr = (rstate == R_CAPTURE) & adc_tick;

  line_reorder #(
    .HALF  (HALF),
    .IDX_W (IDX_W)
  ) u_reorder (
    .clk_sys  (clk_sys),
    .wr_en    (mem_wr),
    .wr_idx   (idx),
    .wr_data  (data_s2),
    .pair_idx (idx),
    .rd_pair  (rd_pair)
  );

  // A frame request while one is still being sent is dropped
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstate       <= R_IDLE;
      idx          <= '0;
      line_no      <= 16'h0000;
      line_shift   <= 1'b0;
      line_active  <= 1'b0;
      frame_active <= 1'b0;
      pixel_pair   <= '0;
      frame_count  <= 32'h0000_0000;
      go_pend      <= 1'b0;
    end else begin
      case (rstate)
        R_IDLE: begin
          // Start on a tick, else a sample from before the request is taken
          if ((frame_go || go_pend) && adc_tick) begin
            go_pend    <= 1'b0;
            rstate     <= R_CAPTURE;
            idx        <= '0;
            line_no    <= 16'h0000;
            line_shift <= 1'b1;
          end else if (frame_go) begin
            go_pend <= 1'b1;
          end
        end
        R_CAPTURE: begin
          // one sample per channel per tick
          if (adc_tick) begin
            if (idx == LAST_IDX) begin
              idx        <= '0;
              line_shift <= 1'b0;
              rstate     <= R_SEND;
            end else begin
              idx <= idx + 1'b1;
            end
          end
        end
        R_SEND: begin
          if (adc_tick) begin
            pixel_pair   <= rd_pair;
            line_active  <= 1'b1;
            frame_active <= 1'b1;
            if (idx == LAST_IDX) begin
              rstate <= R_GAP;
            end else begin
              idx <= idx + 1'b1;
            end
          end
        end
        R_GAP: begin
          if (adc_tick) begin
            line_active <= 1'b0;
            idx         <= '0;
            if (line_no == LAST_LINE) begin
              // frame activity ends after last line
              frame_active <= 1'b0;
              frame_count  <= frame_count + 32'h0000_0001;
              rstate       <= R_IDLE;
            end else begin
              line_no    <= line_no + 16'h0001;
              line_shift <= 1'b1;
              rstate     <= R_CAPTURE;
            end
          end
        end
        default: rstate <= R_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pixel_strobe <= 1'b0;
    end else begin
      pixel_strobe <= (rstate == R_SEND) & adc_tick;
    end
  end

endmodule : exposure_trigger_readout_sequencer

// *** readout_pkg.sv ***
package readout_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_PERIOD_PS   = 8000;
  localparam int T_TAIL_NS       = 77700;
  localparam int T_IDLE_DLY_NS   = 4400;
  localparam int T_JITTER_MAX_NS = 25000;

  // Least times round up, longest times round down, never below one cycle
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_min

  function automatic int cyc_max(input int ns);
    int c;
    c = (ns * 1000) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_max

  localparam int TAIL_CYC_DEF   = cyc_min(T_TAIL_NS);
  localparam int IDLE_DLY_CYC   = cyc_min(T_IDLE_DLY_NS);
  localparam int JITTER_MAX_CYC = cyc_max(T_JITTER_MAX_NS);

  // ==========================================================================
  // Geometry
  // ==========================================================================
  localparam int PIX_BITS       = 10;
  localparam int HALF_PIX       = 502;
  localparam int LINE_COUNT_DEF = 1000;

  // ==========================================================================
  // Register map (byte addresses) and reset values
  // ==========================================================================
  localparam logic [4:0]  ADDR_CTRL     = 5'h00;
  localparam logic [4:0]  ADDR_EXPOSURE = 5'h04;
  localparam logic [4:0]  ADDR_TIMER2   = 5'h08;
  localparam logic [4:0]  ADDR_STATUS   = 5'h0c;
  localparam logic [4:0]  ADDR_FRAMES   = 5'h10;
  localparam int          CTRL_MODE_LSB = 0;
  localparam int          CTRL_RUN_BIT  = 2;
  localparam int          ST_EXPO_BIT   = 0;
  localparam int          ST_FRAME_BIT  = 1;
  localparam int          ST_LINE_BIT   = 2;
  localparam int          ST_XSTATE_LSB = 4;
  localparam int          ST_RSTATE_LSB = 8;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0004;
  localparam logic [31:0] EXPOSURE_RST  = 32'h0000_0208;
  localparam logic [31:0] TIMER2_RST    = 32'h0000_0578;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    MODE_LEVEL = 2'h0,
    MODE_PROG  = 2'h1,
    MODE_FREE  = 2'h2
  } expo_mode_t;

  typedef enum logic [3:0] {
    X_IDLE   = 4'h1,
    X_DELAY  = 4'h2,
    X_EXPOSE = 4'h4,
    X_TAIL   = 4'h8
  } expo_state_t;

  typedef enum logic [3:0] {
    R_IDLE    = 4'h1,
    R_CAPTURE = 4'h2,
    R_SEND    = 4'h4,
    R_GAP     = 4'h8
  } read_state_t;

  typedef struct packed {
    logic [PIX_BITS-1:0] left;
    logic [PIX_BITS-1:0] right;
  } adc_sample_t;

  typedef struct packed {
    logic [PIX_BITS-1:0] first;
    logic [PIX_BITS-1:0] second;
  } pixel_pair_t;

endpackage : readout_pkg

// *** line_reorder.sv ***
`timescale 1ns/10ps
module line_reorder
  import readout_pkg::*;
#(
  parameter int HALF  = HALF_PIX,
  parameter int IDX_W = $clog2(HALF)
) (
  input  wire logic             clk_sys,
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_idx,
  input  wire adc_sample_t      wr_data,
  input  wire logic [IDX_W-1:0] pair_idx,
  output pixel_pair_t           rd_pair
);

  logic [PIX_BITS-1:0] left_mem  [HALF];
  logic [PIX_BITS-1:0] right_mem [HALF];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      left_mem[wr_idx]  <= wr_data.left;
      right_mem[wr_idx] <= wr_data.right;
    end
  end

  // Left half comes in ascending, right half from the far end downward
  always_comb begin
    int k;
    k = int'(pair_idx);
    if (k < HALF / 2) begin
      rd_pair.first  = left_mem[2 * k];
      rd_pair.second = left_mem[2 * k + 1];
    end else begin
      rd_pair.first  = right_mem[2 * HALF - 1 - 2 * k];
      rd_pair.second = right_mem[2 * HALF - 2 - 2 * k];
    end
  end

endmodule : line_reorder

// *** sensor_model.sv ***
`timescale 1ns/10ps
module sensor_model
  import readout_pkg::*;
#(
  parameter int HALF = HALF_PIX
) (
  input  wire logic       line_shift,
  input  wire logic [9:0] off,
  output logic            adc_clk,
  output adc_sample_t     adc_data
);
  int idx = 0;
  int ln  = -1;

  // ==========================================================================
  // Charge pattern and shifting
  // ==========================================================================
  function automatic logic [9:0] val(input int l, input int p);
    return 10'(l * 81 + p * 7) + off;
  endfunction : val

  initial begin
    adc_clk = 1'b0;
    forever #40 adc_clk = ~adc_clk;
  end

  initial adc_data = '0;

  // Counting rises, since the reset fall of line_shift would count too
  always @(posedge line_shift) ln <= ln + 1;

  // ten bits per channel
  // Changed on the falling edge so a sample is settled at its tick
  always @(negedge adc_clk) begin
    if (line_shift === 1'b1) begin
      adc_data <= '{left: val(ln, idx + 1), right: val(ln, 2 * HALF - idx)};
      idx      <= idx + 1;
    end else begin
      // Idle channel toggles, so a stale sample never looks valid
      adc_data <= ~adc_data;
      idx      <= 0;
    end
  end
endmodule : sensor_model

// *** sequencer_properties.sv ***
`timescale 1ns/10ps
module sequencer_properties
  import readout_pkg::*;
#(
  parameter int HALF     = HALF_PIX,
  parameter int LINES    = LINE_COUNT_DEF,
  parameter int TAIL_CYC = TAIL_CYC_DEF
) (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        line_shift,
  input wire logic        frame_active,
  input wire logic        line_active,
  input wire logic        pixel_strobe,
  input wire pixel_pair_t pixel_pair
);
  int   pcnt;
  int   lcnt;
  logic la_q;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Pair and line counters
  // ==========================================================================
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pcnt <= 0;
      lcnt <= 0;
      la_q <= 1'b0;
    end else begin
      la_q <= line_active;
      pcnt <= !line_active ? 0 : pcnt + int'(pixel_strobe);
      lcnt <= !frame_active ? 0 : lcnt + int'(line_active && !la_q);
    end
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  a_line_in_frame: assert property (line_active |-> frame_active)
    else $error("line active outside frame");
  a_frame_open_line: assert property (
    $rose(frame_active) |-> $rose(line_active) && pixel_strobe)
    else $error("frame start without first pair");
  a_frame_close_line: assert property (
    $fell(frame_active) |-> $fell(line_active))
    else $error("frame end not on last line end");
  a_strobe_in_line: assert property (pixel_strobe |-> line_active)
    else $error("pair outside line");
  a_strobe_paced: assert property (pixel_strobe |=> !pixel_strobe [*8])
    else $error("pairs faster than data rate");
  a_pair_holds: assert property (!pixel_strobe |-> $stable(pixel_pair))
    else $error("pair changed without strobe");
  a_line_width: assert property ($fell(line_active) |-> pcnt == HALF)
    else $error("wrong pair count in line");
  a_frame_lines: assert property ($fell(frame_active) |-> lcnt == LINES)
    else $error("wrong line count in frame");
  a_shift_apart: assert property (line_shift |-> !line_active)
    else $error("capture overlaps sending");
  a_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer held too long");
endmodule : sequencer_properties

bind exposure_trigger_readout_sequencer sequencer_properties #(
  .HALF(HALF), .LINES(LINES), .TAIL_CYC(TAIL_CYC)
) props (
  .clk_sys(clk_sys), .rst_n(rst_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .line_shift(line_shift), .frame_active(frame_active),
  .line_active(line_active), .pixel_strobe(pixel_strobe),
  .pixel_pair(pixel_pair)
);

// *** exposure_trigger_readout_sequencer_bench.sv ***
`timescale 1ns/10ps
module exposure_trigger_readout_sequencer_bench
  import readout_pkg::*;
();
  localparam int HALF  = 8;
  localparam int LINES = 2;
  localparam int TAIL  = 20;
  logic        clk_sys, adc_clk, expo, line_shift, avs_waitrequest;
  logic        frame_active, line_active, pixel_strobe, la_q, fa_q;
  logic        rst_n      = 1'b0;
  logic        avs_read   = 1'b0;
  logic        avs_write  = 1'b0;
  logic        trigger_in = 1'b1;
  logic [4:0]  avs_address   = '0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata, r;
  logic [9:0]  off = '0;
  adc_sample_t adc_data;
  pixel_pair_t pixel_pair;
  int          failures, total_checks, cyc, frames, lines, k, lf, e, t0, t1;
  logic [4:0]  ra[4] = '{ADDR_CTRL, ADDR_EXPOSURE, ADDR_TIMER2, 5'h14};
  logic [31:0] rv[4] = '{CTRL_RST, EXPOSURE_RST, TIMER2_RST, 32'h0};

  exposure_trigger_readout_sequencer #(
    .HALF(HALF), .LINES(LINES), .TAIL_CYC(TAIL)
  ) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .trigger_in(trigger_in), .adc_clk(adc_clk), .adc_data(adc_data),
    .line_shift(line_shift), .exposure_active_output(expo),
    .frame_active(frame_active), .line_active(line_active),
    .pixel_strobe(pixel_strobe), .pixel_pair(pixel_pair)
  );

  sensor_model #(.HALF(HALF)) far (
    .line_shift(line_shift), .off(off), .adc_clk(adc_clk),
    .adc_data(adc_data)
  );

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // Checking and bus tasks
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    if (failures == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  task automatic bus_req(input logic [4:0] a, input logic wr,
                         input logic [31:0] d);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus_req

  // These waits have no limit of their own; the bench timeout ends one that never completes
  task automatic wait_expo(input logic lvl);
    while (expo !== lvl) begin
      @(posedge clk_sys);
    end
  endtask : wait_expo

  task automatic wait_frames(input int target);
    while (frames < target) begin
      @(posedge clk_sys);
    end
  endtask : wait_frames

  // Exposure under level trigger; busy means the fall lands mid-frame
  task automatic level_frame(input bit busy);
    int n, d, tr, want, len;
    n = 0;
    @(posedge clk_sys);
    while (busy && frame_active !== 1'b1 && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    trigger_in <= 1'b0;
    t0 = cyc;
    wait_expo(1'b1);
    d = cyc - t0;
    if (busy)
      check(32'(d > 0 && d <= JITTER_MAX_CYC + 5), 1);
    else
      check(32'(d >= IDLE_DLY_CYC && d <= IDLE_DLY_CYC + 6), 1);
    repeat (1300) @(posedge clk_sys);
    trigger_in <= 1'b1;
    tr = cyc;
    wait_expo(1'b0);
    len  = cyc - t0 - d;
    want = tr - t0 + TAIL - (busy ? d : 0);
    check(32'(len >= want - 4 && len <= want + 4), 1);
  endtask : level_frame

  // ==========================================================================
  // Video monitor and timeout
  // ==========================================================================
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (rst_n) begin
      la_q <= line_active;
      fa_q <= frame_active;
      if (pixel_strobe === 1'b1) begin
        check({12'h0, pixel_pair}, {12'h0, far.val(lines, 2 * k + 1),
              far.val(lines, 2 * k + 2)});
        k <= k + 1;
      end
      if (la_q === 1'b1 && line_active === 1'b0) begin
        check(k, HALF);
        lines <= lines + 1;
        k     <= 0;
      end
      if (la_q === 1'b0 && line_active === 1'b1)
        lf <= lf + 1;
      if (fa_q === 1'b1 && frame_active === 1'b0) begin
        check(lf, LINES);
        frames <= frames + 1;
        lf     <= 0;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (cyc == 60000) begin
      failures++;
      complete_run();
    end
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    void'($urandom(32));
    off <= 10'($urandom);
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    bus_req(5'h14, 1'b1, 32'hffff_ffff);
    for (int i = 0; i < 4; i++) begin
      bus_req(ra[i], 1'b0, 32'h0);
      check(r, rv[i]);
    end
    level_frame(1'b0);
    level_frame(1'b1);
    wait_frames(2);
    check(frames, 2);
    for (int i = 0; i < 2; i++) begin
      e = 330 + $urandom % 40;
      bus_req(ADDR_EXPOSURE, 1'b1, e);
      bus_req(ADDR_EXPOSURE, 1'b0, 32'h0);
      check(r, e);
      bus_req(ADDR_CTRL, 1'b1, {29'h0, 1'b1, MODE_PROG});
      trigger_in <= 1'b0;
      repeat (700) @(posedge clk_sys);
      check(expo, 0);
      trigger_in <= 1'b1;
      t0 = cyc;
      wait_expo(1'b1);
      check(32'(cyc - t0 <= 6), 1);
      t1 = cyc;
      repeat (600) @(posedge clk_sys);
      trigger_in <= 1'b0;
      wait_expo(1'b0);
      t1 = cyc - t1 - (e + 1) * 10 - TAIL;
      check(32'(t1 >= -12 && t1 <= 12), 1);
      wait_frames(3 + i);
    end
    bus_req(ADDR_TIMER2, 1'b1, 32'h1e);
    bus_req(ADDR_CTRL, 1'b1, {29'h0, 1'b1, MODE_FREE});
    wait_frames(6);
    check(32'(frames >= 6), 1);
    bus_req(ADDR_FRAMES, 1'b0, 32'h0);
    check(r, frames);
    complete_run();
  end
endmodule : exposure_trigger_readout_sequencer_bench
